// ---- rtl/dac_write_decoder.sv ----
// module: decodes host write words into per-channel register updates
// Function
// - selector 11 targets input code, 10 offset, 01 gain, 00 the special function register.
// - input code words are straight binary, code over 16384 of the positive reference.
// - offset words are offset binary, midscale meaning zero, range -8192 to +8191 LSB.
// - gain uses only the upper thirteen data bits, gain being code plus one over 8192.
// - step writes keep the top five bits zero and use the low seven bits as step size.
// - the direction bit set means increment, clear means decrement.
// - step results clamp at full scale or zero instead of wrapping.
// - a special function write of all ones is a soft reset to reference ground.
// - every write carries an 8-bit address so each channel register can be written alone.
// - the upper address nibble is a group mask, all zero selecting all 40 channels.
// - the lower nibble is a register index 0 to 9 within each selected group.
// - with all channels selected the register index is ignored.
module dac_write_decoder #(
    parameter int NCH = 40
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic write_strobe,
    input wire logic target_select_hi,
    input wire logic target_select_lo,
    input wire logic [13:0] write_word_bits,
    input wire logic [7:0] write_addr,
    output logic [NCH*14-1:0] input_code_flat,
    output logic [NCH*14-1:0] offset_flat,
    output logic [NCH*13-1:0] gain_flat,
    output logic [NCH-1:0] out_at_ground,
    output logic soft_reset_pulse,
    output logic step_word_error,
    output logic write_done
);
    // the channel map is fixed at four groups of ten
    if (NCH != dac_dec_pkg::CHANNELS) begin : g_bad_nch
        $error("channel count must be 40");
    end

    typedef struct packed {
        logic [NCH-1:0][13:0] code;
        logic [NCH-1:0][13:0] offs;
        logic [NCH-1:0][12:0] gain;
        logic [NCH-1:0] gnd;
        logic rst_p;
        logic err;
        logic done;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    chan_sel_if csel ();
    dac_dec_pkg::op_t op;
    logic [6:0] step;
    logic dir_up;

    chan_select u_sel (
        .sel(csel)
    );

    assign csel.group_mask_bits = write_addr[7:4];
    assign csel.channel_index_bits = write_addr[3:0];
    assign step = write_word_bits[dac_dec_pkg::STEP_W-1:0];
    assign dir_up = write_word_bits[dac_dec_pkg::DIR_BIT];

    // saturating add/sub; a 15-bit sum keeps the carry for clamp detection
    function automatic logic [13:0] step_apply(input logic [13:0] v, input logic [6:0] s,
                                               input logic up);
        logic [14:0] t;
        t = '0;
        if (up) begin
            t = {1'b0, v} + {8'h00, s};
            step_apply = t[14] ? dac_dec_pkg::CODE_FULL : t[13:0];
        end else begin
            t = {1'b0, v} - {8'h00, s};
            step_apply = t[14] ? dac_dec_pkg::CODE_ZERO : t[13:0];
        end
    endfunction : step_apply

    always_comb begin
        op = dac_dec_pkg::OP_NONE;
        if (write_strobe) begin
            unique case ({target_select_hi, target_select_lo})
                dac_dec_pkg::SEL_DATA: op = dac_dec_pkg::OP_DATA;
                dac_dec_pkg::SEL_OFFSET: op = dac_dec_pkg::OP_OFFSET;
                dac_dec_pkg::SEL_GAIN: op = dac_dec_pkg::OP_GAIN;
                dac_dec_pkg::SEL_SPECIAL: begin
                    if (write_word_bits == dac_dec_pkg::SOFT_RESET_WORD) begin
                        op = dac_dec_pkg::OP_SOFT_RESET;
                    end else if (write_word_bits[13:dac_dec_pkg::STEP_HI_LSB] == 5'h00) begin
                        op = dac_dec_pkg::OP_STEP;
                    end else begin
                        op = dac_dec_pkg::OP_BAD;
                    end
                end
            endcase
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rst_p = 1'b0;
        st_nxt.done = write_strobe;
        st_nxt.err = (op == dac_dec_pkg::OP_BAD);
        if (op == dac_dec_pkg::OP_SOFT_RESET) begin
            // soft reset restores power-on values and parks outputs
            for (int c = 0; c < NCH; c++) begin
                st_nxt.code[c] = dac_dec_pkg::CODE_ZERO;
                st_nxt.offs[c] = dac_dec_pkg::OFFSET_MID;
                st_nxt.gain[c] = dac_dec_pkg::GAIN_FULL;
            end
            st_nxt.gnd = '1;
            st_nxt.rst_p = 1'b1;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (csel.chan_mask[c]) begin
                    unique case (op)
                        dac_dec_pkg::OP_DATA: begin
                            st_nxt.code[c] = write_word_bits;
                            st_nxt.gnd[c] = 1'b0;
                        end
                        dac_dec_pkg::OP_OFFSET: st_nxt.offs[c] = write_word_bits;
                        dac_dec_pkg::OP_GAIN: begin
                            st_nxt.gain[c] = write_word_bits[13:dac_dec_pkg::GAIN_LSB];
                        end
                        dac_dec_pkg::OP_STEP: begin
                            // zero step leaves the value whatever the direction
                            st_nxt.code[c] = step_apply(st_r.code[c], step, dir_up);
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int c = 0; c < NCH; c++) begin
                st_r.code[c] <= dac_dec_pkg::CODE_ZERO;
                st_r.offs[c] <= dac_dec_pkg::OFFSET_MID;
                st_r.gain[c] <= dac_dec_pkg::GAIN_FULL;
            end
            st_r.gnd <= '1;
            st_r.rst_p <= 1'b0;
            st_r.err <= 1'b0;
            st_r.done <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign input_code_flat = st_r.code;
    assign offset_flat = st_r.offs;
    assign gain_flat = st_r.gain;
    assign out_at_ground = st_r.gnd;
    assign soft_reset_pulse = st_r.rst_p;
    assign step_word_error = st_r.err;
    assign write_done = st_r.done;
endmodule : dac_write_decoder

// ---- inc/dac_dec_pkg.sv ----
// package: constants and types shared by the write decoder files
package dac_dec_pkg;
    localparam int DATA_W = 14;
    localparam int ADDR_W = 8;
    localparam int SEL_W = 2;
    localparam int GROUPS = 4;
    localparam int PER_GROUP = 10;
    localparam int CHANNELS = 40;
    localparam int CH_W = 6;
    localparam int STEP_W = 7;
    localparam int DIR_BIT = 8;
    localparam int STEP_HI_LSB = 9;
    localparam int GAIN_LSB = 1;
    localparam logic [1:0] SEL_DATA = 2'h3;
    localparam logic [1:0] SEL_OFFSET = 2'h2;
    localparam logic [1:0] SEL_GAIN = 2'h1;
    localparam logic [1:0] SEL_SPECIAL = 2'h0;
    localparam logic [13:0] CODE_ZERO = 14'h0000;
    localparam logic [13:0] CODE_FULL = 14'h3fff;
    localparam logic [13:0] OFFSET_MID = 14'h2000;
    localparam logic [12:0] GAIN_FULL = 13'h1fff;
    localparam logic [13:0] SOFT_RESET_WORD = 14'h3fff;
    localparam logic [3:0] GROUP_ALL = 4'h0;
    localparam logic [3:0] INDEX_MAX = 4'h9;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_DATA = 3'h1,
        OP_OFFSET = 3'h3,
        OP_GAIN = 3'h2,
        OP_STEP = 3'h6,
        OP_SOFT_RESET = 3'h7,
        OP_BAD = 3'h5
    } op_t;
endpackage : dac_dec_pkg

// ---- inc/chan_sel_if.sv ----
// interface: carries the address fields to the channel selector and its mask back
interface chan_sel_if;
    logic [3:0] group_mask_bits;
    logic [3:0] channel_index_bits;
    logic [39:0] chan_mask;
    modport decoder (output group_mask_bits, output channel_index_bits, input chan_mask);
    modport selector (input group_mask_bits, input channel_index_bits, output chan_mask);
endinterface : chan_sel_if

// ---- rtl/chan_select.sv ----
// module: turns group mask and register index into a 40-channel select mask
module chan_select (
    chan_sel_if.selector sel
);
    always_comb begin
        sel.chan_mask = '0;
        if (sel.group_mask_bits == dac_dec_pkg::GROUP_ALL) begin
            sel.chan_mask = '1;
        end else if (sel.channel_index_bits <= dac_dec_pkg::INDEX_MAX) begin
            for (int g = 0; g < dac_dec_pkg::GROUPS; g++) begin
                if (sel.group_mask_bits[g]) begin
                    sel.chan_mask[g * dac_dec_pkg::PER_GROUP
                        + int'(sel.channel_index_bits)] = 1'b1;
                end
            end
        end
    end
endmodule : chan_select

// ---- testbench/host_model.sv ----
// host side: drives one registered write word per request onto the decoder pins
module host_model (
    input wire logic mclk,
    input wire logic req,
    input wire logic rogue,
    input wire logic [23:0] cmd,
    output logic write_strobe,
    output logic [23:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pins = 24'h00_0000;
    // idle pins toggle so no stale word looks valid
    // one assignment per edge; a step word gets its top five bits cleared here
    always @(posedge mclk) begin
        write_strobe <= req;
        if (req && cmd[23:22] == 2'h0 && cmd[21:8] != 14'h3fff && !rogue)
            pins <= {cmd[23:22], 5'h00, cmd[16:0]};
        else
            pins <= req ? cmd : ~pins;
    end
endmodule : host_model

// ---- testbench/dac_dec_chk.sv ----
// checker: decode and timing relations at the write decoder ports
module dac_dec_chk #(parameter int NCH = 40) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic write_strobe,
    input wire logic target_select_hi,
    input wire logic target_select_lo,
    input wire logic [13:0] write_word_bits,
    input wire logic [7:0] write_addr,
    input wire logic [NCH*14-1:0] input_code_flat,
    input wire logic [NCH*14-1:0] offset_flat,
    input wire logic [NCH*13-1:0] gain_flat,
    input wire logic [NCH-1:0] out_at_ground,
    input wire logic soft_reset_pulse,
    input wire logic step_word_error,
    input wire logic write_done
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [13:0] w_q;
    wire logic [1:0] sel = {target_select_hi, target_select_lo};
    wire logic take = write_strobe && !sys_rst;
    wire logic spec = take && sel == 2'h0;
    always_ff @(posedge mclk) w_q <= write_word_bits;
    a_done_follows: assert property (take |=> write_done)
        else $error("no done after write");
    a_done_only: assert property (!write_strobe |=> !write_done)
        else $error("done without write");
    a_soft_reset: assert property (spec && write_word_bits == 14'h3fff |=>
        soft_reset_pulse && &out_at_ground && input_code_flat == '0) else $error("soft reset");
    a_code_all: assert property (take && sel == 2'h3 && write_addr[7:4] == 4'h0 |=>
        input_code_flat[13:0] == w_q && input_code_flat[NCH*14-1 -: 14] == w_q
        && out_at_ground == '0) else $error("broadcast code");
    a_gain_upper: assert property (take && sel == 2'h1 && write_addr == 8'h10 |=>
        gain_flat[12:0] == w_q[13:1]) else $error("gain field");
    a_offset_chan: assert property (take && sel == 2'h2 && write_addr == 8'h23 |=>
        offset_flat[14*13 +: 14] == w_q) else $error("offset channel");
    a_bad_index: assert property (take && write_addr[7:4] != 4'h0 && write_addr[3:0] > 4'h9
        && !(sel == 2'h0 && write_word_bits == 14'h3fff)
        |=> $stable(input_code_flat) && $stable(gain_flat)) else $error("index");
    a_step_reject: assert property (spec && write_word_bits[13:9] != 5'h00
        && write_word_bits != 14'h3fff |=> step_word_error && $stable(input_code_flat))
        else $error("bad step word");
    c_reset: cover property (soft_reset_pulse);
    c_error: cover property (step_word_error);
    c_step: cover property (spec ##1 write_done);
endmodule : dac_dec_chk

bind dac_write_decoder dac_dec_chk #(.NCH(NCH)) i_chk (.*);

// ---- testbench/tb.sv ----
// bench: corner and random writes checked against a model of all channels
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, sys_rst = 1, req = 0, rogue = 0, write_strobe;
    logic [23:0] cmd = 24'h00_0000, pins;
    logic soft_reset_pulse, step_word_error, write_done;
    logic [559:0] code_f, off_f;
    logic [519:0] gain_f;
    logic [39:0] gnd_f, gnd;
    logic [13:0] code [40], off [40];
    logic [12:0] gn [40];
    int n_errors = 0, checked = 0;
    always #25 mclk = ~mclk;
    host_model i_host (.mclk(mclk), .req(req), .rogue(rogue), .cmd(cmd),
        .write_strobe(write_strobe), .pins(pins));
    dac_write_decoder i_dut (.mclk(mclk), .sys_rst(sys_rst), .write_strobe(write_strobe),
        .target_select_hi(pins[23]), .target_select_lo(pins[22]),
        .write_word_bits(pins[21:8]), .write_addr(pins[7:0]), .input_code_flat(code_f),
        .offset_flat(off_f), .gain_flat(gain_f), .out_at_ground(gnd_f),
        .soft_reset_pulse(soft_reset_pulse), .step_word_error(step_word_error),
        .write_done(write_done));
    function automatic logic hit(input logic [7:0] a, input int c);
        return a[7:4] == 4'h0 || (a[4 + c / 10] && a[3:0] == 4'(c % 10));
    endfunction : hit
    function automatic logic [13:0] step(input logic [13:0] v, input logic [13:0] w);
        logic [14:0] t;
        t = w[8] ? v + w[6:0] : v - w[6:0];
        return t[14] ? (w[8] ? 14'h3fff : 14'h0000) : t[13:0];
    endfunction : step
    task automatic chk(input string n, input logic [559:0] s, input logic [559:0] e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic cmp_all;
        logic [559:0] ec, eo, eg;
        eg = '0;
        for (int c = 0; c < 40; c++) begin
            ec[14*c +: 14] = code[c];
            eo[14*c +: 14] = off[c];
            eg[13*c +: 13] = gn[c];
        end
        chk("codes", code_f, ec);
        chk("offsets", off_f, eo);
        chk("gains", {40'h0, gain_f}, eg);
        chk("ground", gnd_f, gnd);
    endtask : cmp_all
    task automatic wr(input logic [1:0] s, input logic [13:0] w, input logic [7:0] a,
        input logic r = 0);
        @(posedge mclk);
        {req, rogue, cmd} <= {1'b1, r, s, w, a};
        @(posedge mclk);
        req <= 0;
        // the host clears the top of a step word unless told to misbehave
        if (s == 2'h0 && w != 14'h3fff && !r) w[13:9] = 5'h00;
        for (int c = 0; c < 40; c++)
            if (s == 2'h0 && w == 14'h3fff)
                {code[c], off[c], gn[c], gnd[c]} = {14'h0000, 14'h2000, 13'h1fff, 1'b1};
            else if (hit(a, c))
                case (s)
                    2'h3: {code[c], gnd[c]} = {w, 1'b0};
                    2'h2: off[c] = w;
                    2'h1: gn[c] = w[13:1];
                    default: if (w[13:9] == 5'h00) code[c] = step(code[c], w);
                endcase
        for (int i = 0; i < 4 && write_done !== 1'b1; i++) @(negedge mclk);
        chk("done", write_done, 1);
        chk("reset pulse", soft_reset_pulse, s == 2'h0 && w == 14'h3fff);
        chk("step error", step_word_error, s == 2'h0 && w[13:9] != 0 && w != 14'h3fff);
        cmp_all();
    endtask : wr
    task automatic finish_test;
        if (n_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    initial begin
        #250000;
        n_errors++;
        finish_test();
    end
    initial begin
        void'($urandom(25));
        for (int c = 0; c < 40; c++)
            {code[c], off[c], gn[c], gnd[c]} = {14'h0000, 14'h2000, 13'h1fff, 1'b1};
        repeat (3) @(posedge mclk);
        sys_rst <= 0;
        @(negedge mclk);
        cmp_all();
        wr(2'h3, 14'h3ff0, 8'h00);
        wr(2'h0, 14'h017f, 8'h00);
        wr(2'h3, 14'h0005, 8'hf9);
        wr(2'h0, 14'h007f, 8'hf9);
        wr(2'h0, 14'h0100, 8'h15);
        wr(2'h1, 14'h2aab, 8'h10);
        wr(2'h2, 14'h0001, 8'h23);
        wr(2'h3, 14'h0abc, 8'h5c);
        wr(2'h0, 14'h1e00, 8'h00, 1);
        wr(2'h0, 14'h3fff, 8'h47);
        repeat (300) wr(2'($urandom), 14'($urandom), 8'($urandom));
        finish_test();
    end
endmodule : tb
